// [design/watchdog_pkg.sv]
package watchdog_pkg;

  // ****************************************
  // Widths and clock
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 14;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_REFRESH = 8'h30;
  localparam logic [7:0] OFF_CTRL    = 8'h32;
  localparam logic [7:0] OFF_STATUS  = 8'h34;
  localparam logic [7:0] OFF_RSTSEL  = 8'h36;
  localparam logic [7:0] OFF_SLEEP   = 8'h38;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TIMEOUT_SELECT_LSB   = 0;
  localparam int CKS_LSB    = 4;
  localparam int WINDOW_END_SELECT_LSB   = 8;
  localparam int WINDOW_START_SELECT_LSB   = 12;
  localparam int SEL_BIT    = 7;
  localparam int UNDF_BIT   = 14;
  localparam int REFERR_BIT = 15;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [15:0] CTRL_RST   = 16'h3303;
  localparam logic [15:0] CTRL_MASK  = 16'h33f3;
  localparam logic [7:0]  SEL_RST    = 8'h00;
  localparam logic [7:0]  REFR_RST   = 8'hff;
  localparam logic [7:0]  KICK_FIRST = 8'h00;
  localparam logic [7:0]  KICK_LAST  = 8'hff;

  localparam logic [3:0] DIV_1   = 4'h0;
  localparam logic [3:0] DIV_16  = 4'h2;
  localparam logic [3:0] DIV_32  = 4'h3;
  localparam logic [3:0] DIV_64  = 4'h4;
  localparam logic [3:0] DIV_128 = 4'hf;
  localparam logic [3:0] DIV_256 = 4'h5;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic       sleep_stop;
    logic       reset_sel;
    logic [1:0] win_start;
    logic [1:0] win_end;
    logic [3:0] divide;
    logic [1:0] timeout;
  } wdt_cfg_t;

  typedef enum logic [1:0] {
    WAIT_CFG,
    STOPPED,
    COUNTING
  } wdt_state_t;

endpackage

// [design/independent_watchdog.sv]
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
module independent_watchdog (
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_b_in,
  // Register port
  input  watchdog_pkg::bus_req_t    bus_in,
  output logic [watchdog_pkg::DATA_W-1:0] rdata_out,
  // Count source and option word
  input  wire logic                 low_speed_clk_in,
  input  wire logic                 auto_start_in,
  input  watchdog_pkg::wdt_cfg_t    opt_word_in,
  // Power state
  input  wire logic                 sleep_in,
  // Requests
  output logic                      reset_req_out,
  output logic                      nmi_req_out,
  output logic                      count_stop_out
);
  import watchdog_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [8:0] ratio_of(input logic [3:0] code);
    unique case (code)
      DIV_16:  ratio_of = 9'h010;
      DIV_32:  ratio_of = 9'h020;
      DIV_64:  ratio_of = 9'h040;
      DIV_128: ratio_of = 9'h080;
      DIV_256: ratio_of = 9'h100;
      default: ratio_of = 9'h001;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] period_of(input logic [1:0] code);
    unique case (code)
      2'b00: period_of = 14'h0080;
      2'b01: period_of = 14'h0200;
      2'b10: period_of = 14'h0400;
      default: period_of = 14'h0800;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] quarter(input logic [CNT_W-1:0] n,
                                               input logic [2:0] q);
    logic [CNT_W-1:0] part;
    part    = n >> 2;
    quarter = CNT_W'(part * q);
  endfunction

  // ****************************************
  // Reset and input synchronisers
  // ****************************************
  logic       rst_meta;
  logic       rst_n;
  logic       src_meta;
  logic       src_sync;
  logic       src_prev;
  logic       tick;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      src_meta <= 1'b0;
      src_sync <= 1'b0;
      src_prev <= 1'b0;
    end else begin
      src_meta <= low_speed_clk_in;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  assign tick = src_sync & ~src_prev;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Register side state
  // ****************************************
  logic [15:0]       ctrl;
  logic [15:0]       next_ctrl;
  logic [7:0]        rstsel;
  logic [7:0]        next_rstsel;
  logic [7:0]        sleepreg;
  logic [7:0]        next_sleepreg;
  logic [7:0]        refr_rd;
  logic [7:0]        next_refr_rd;
  logic              armed;
  logic              next_armed;
  logic              locked;
  logic              next_locked;
  logic              undf_flag;
  logic              next_undf_flag;
  logic              err_flag;
  logic              next_err_flag;
  logic [DATA_W-1:0] next_rdata;
  logic              kick;
  wdt_cfg_t          cfg_reg;

  // ****************************************
  // Counter side state
  // ****************************************
  wdt_state_t        state;
  wdt_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [8:0]        presc;
  logic [8:0]        next_presc;
  wdt_cfg_t          act;
  wdt_cfg_t          next_act;
  logic              auto_mode;
  logic              next_auto_mode;
  logic              next_reset_req;
  logic              next_nmi_req;
  logic              next_count_stop;
  logic              underflow;
  logic              ref_err;
  logic              in_win;
  logic              paused;
  logic [CNT_W-1:0]  win_hi;
  logic [CNT_W-1:0]  win_lo;
  logic [CNT_W-1:0]  period;

  assign cfg_reg.timeout    = ctrl[TIMEOUT_SELECT_LSB +: 2];
  assign cfg_reg.divide     = ctrl[CKS_LSB +: 4];
  assign cfg_reg.win_end    = ctrl[WINDOW_END_SELECT_LSB +: 2];
  assign cfg_reg.win_start  = ctrl[WINDOW_START_SELECT_LSB +: 2];
  assign cfg_reg.reset_sel  = rstsel[SEL_BIT];
  assign cfg_reg.sleep_stop = sleepreg[SEL_BIT];

  // ****************************************
  // Register decode
  // ****************************************
  always_comb begin
    next_ctrl      = ctrl;
    next_rstsel    = rstsel;
    next_sleepreg  = sleepreg;
    next_refr_rd   = refr_rd;
    next_armed     = armed;
    next_locked    = locked | auto_mode;
    next_undf_flag = undf_flag | underflow;
    next_err_flag  = err_flag | ref_err;
    next_rdata     = '0;
    kick           = 1'b0;
    if (bus_in.wr) begin
      next_armed = 1'b0;
      unique case (bus_in.addr)
        OFF_REFRESH: begin
          next_refr_rd = (bus_in.wdata[7:0] == KICK_FIRST) ?
                         KICK_FIRST : KICK_LAST;
          if (bus_in.wdata[7:0] == KICK_FIRST) begin
            next_armed = 1'b1;
          end else if (armed && bus_in.wdata[7:0] == KICK_LAST) begin
            kick = 1'b1;
          end
        end
        OFF_CTRL: begin
          if (!locked) begin
            next_ctrl = bus_in.wdata & CTRL_MASK;
          end
        end
        OFF_RSTSEL: begin
          if (!locked) begin
            next_rstsel = bus_in.wdata[7:0] & 8'h80;
          end
        end
        OFF_SLEEP: begin
          if (!locked) begin
            next_sleepreg = bus_in.wdata[7:0] & 8'h80;
          end
        end
        OFF_STATUS: begin
          next_undf_flag = underflow |
                           (undf_flag & bus_in.wdata[UNDF_BIT]);
          next_err_flag  = ref_err |
                           (err_flag & bus_in.wdata[REFERR_BIT]);
        end
        default: begin
        end
      endcase
    end
    if (kick) begin
      next_locked = 1'b1;
    end
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFF_REFRESH: next_rdata = {8'h00, refr_rd};
        OFF_CTRL:    next_rdata = ctrl;
        OFF_STATUS:  next_rdata = {err_flag, undf_flag, cnt};
        OFF_RSTSEL:  next_rdata = {8'h00, rstsel};
        OFF_SLEEP:   next_rdata = {8'h00, sleepreg};
        default:     next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= CTRL_RST;
      rstsel    <= SEL_RST;
      sleepreg  <= SEL_RST;
      refr_rd   <= REFR_RST;
      armed     <= 1'b0;
      locked    <= 1'b0;
      undf_flag <= 1'b0;
      err_flag  <= 1'b0;
      rdata_out <= '0;
    end else begin
      ctrl      <= next_ctrl;
      rstsel    <= next_rstsel;
      sleepreg  <= next_sleepreg;
      refr_rd   <= next_refr_rd;
      armed     <= next_armed;
      locked    <= next_locked;
      undf_flag <= next_undf_flag;
      err_flag  <= next_err_flag;
      rdata_out <= next_rdata;
    end
  end

  // ****************************************
  // Window and counter
  // ****************************************
  always_comb begin
    period = period_of(act.timeout);
    win_hi = quarter(period, 3'(act.win_start) + 3'd1) - 14'h0001;
    win_lo = quarter(period, 3'd3 - 3'(act.win_end));
    in_win = (cnt <= win_hi) && (cnt >= win_lo);
    paused = sleep_in & act.sleep_stop;
  end

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_presc      = presc;
    next_act        = act;
    next_auto_mode  = auto_mode;
    next_reset_req  = 1'b0;
    next_nmi_req    = 1'b0;
    next_count_stop = paused;
    underflow       = 1'b0;
    ref_err         = 1'b0;
    unique case (state)
      WAIT_CFG: begin
        next_auto_mode = auto_start_in;
        next_presc     = '0;
        if (auto_start_in) begin
          next_act   = opt_word_in;
          next_cnt   = period_of(opt_word_in.timeout) - 14'h0001;
          next_state = COUNTING;
        end else begin
          next_state = STOPPED;
        end
      end
      STOPPED: begin
        next_presc = '0;
        if (auto_mode || kick) begin
          if (!auto_mode) begin
            next_act = cfg_reg;
          end
          next_cnt   = period_of(auto_mode ? act.timeout : cfg_reg.timeout)
                       - 14'h0001;
          next_state = COUNTING;
        end
      end
      COUNTING: begin
        if (kick && !in_win) begin
          ref_err    = 1'b1;
          next_state = STOPPED;
        end else if (kick) begin
          next_cnt   = period - 14'h0001;
          next_presc = '0;
        end else if (tick && !paused) begin
          if (presc == ratio_of(act.divide) - 9'h001) begin
            next_presc = '0;
            if (cnt == '0) begin
              underflow  = 1'b1;
              next_state = STOPPED;
            end else begin
              next_cnt = cnt - 14'h0001;
            end
          end else begin
            next_presc = presc + 9'h001;
          end
        end
      end
    endcase
    if (underflow || ref_err) begin
      next_reset_req = act.reset_sel;
      next_nmi_req   = ~act.reset_sel;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state          <= WAIT_CFG;
      cnt            <= '0;
      presc          <= '0;
      act            <= '0;
      auto_mode      <= 1'b0;
      reset_req_out  <= 1'b0;
      nmi_req_out    <= 1'b0;
      count_stop_out <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      presc          <= next_presc;
      act            <= next_act;
      auto_mode      <= next_auto_mode;
      reset_req_out  <= next_reset_req;
      nmi_req_out    <= next_nmi_req;
      count_stop_out <= next_count_stop;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_kick_reload: assert property (
    state == COUNTING && kick && in_win |=> cnt == period - 14'h0001)
    else $error("refresh did not reload the counter");

  a_error_stops: assert property (
    state == COUNTING && kick && !in_win
    |=> state == STOPPED && (reset_req_out || nmi_req_out))
    else $error("refresh error did not stop and signal");

  a_underflow_req: assert property (
    underflow |=> (reset_req_out == $past(act.reset_sel))
               && (nmi_req_out == !$past(act.reset_sel)))
    else $error("underflow routed to the wrong output");

  a_auto_restart: assert property (
    state == STOPPED && auto_mode |=> state == COUNTING)
    else $error("auto mode did not restart");

  a_reg_waits: assert property (
    state == STOPPED && !auto_mode && !kick |=> state == STOPPED)
    else $error("register mode started without refresh");

  a_count_step: assert property (
    state == COUNTING && tick && !paused && !kick && cnt != '0
    && presc == ratio_of(act.divide) - 9'h001
    |=> cnt == $past(cnt) - 14'h0001)
    else $error("counter did not step down");

  a_sleep_hold: assert property (
    state == COUNTING && paused && !kick |=> $stable(cnt))
    else $error("counter moved while stopped for sleep");

  a_refresh_read: assert property (
    bus_in.rd && bus_in.addr == OFF_REFRESH
    |=> rdata_out[7:0] == KICK_FIRST || rdata_out[7:0] == KICK_LAST)
    else $error("refresh register read an illegal value");

  a_one_output: assert property (
    !(reset_req_out && nmi_req_out))
    else $error("reset and interrupt requested together");

endmodule

// [bench/count_source_model.sv]
`timescale 1ns/1ns
module count_source_model (
  // Clock, reset and gate
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       en_in,
  // Requests from the watchdog
  input  wire logic       reset_req_in,
  input  wire logic       nmi_req_in,
  // Count source and tallies
  output logic            lsclk_out,
  output logic [7:0]      reset_cnt_out,
  output logic [7:0]      nmi_cnt_out
);
  // ****************************************
  // Count source
  // ****************************************
  logic [2:0] phase;

  // Eight bus cycles per tick, far above the minimum ratio
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase <= 3'h0;
    end else if (en_in) begin
      phase <= phase + 3'h1;
    end
  end

  // Stands low whenever the gate closes on a whole tick
  assign lsclk_out = phase[2];

  // ****************************************
  // Request tallies
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_cnt_out <= 8'h00;
      nmi_cnt_out   <= 8'h00;
    end else begin
      reset_cnt_out <= reset_cnt_out + {7'h00, reset_req_in};
      nmi_cnt_out   <= nmi_cnt_out + {7'h00, nmi_req_in};
    end
  end
endmodule

// [bench/independent_watchdog_tb_top.sv]
`timescale 1ns/1ns
module independent_watchdog_tb_top;
  import watchdog_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic              mclk_in;
  logic              rst_b;
  bus_req_t          bus_r;
  logic [15:0]       rdata;
  logic              lsclk;
  logic              auto_r;
  wdt_cfg_t          opt_r;
  logic              sleep_r;
  logic              en_r;
  logic              reset_req;
  logic              nmi_req;
  logic              count_stop;
  logic [7:0]        reset_cnt;
  logic [7:0]        nmi_cnt;
  logic [15:0]       v;
  logic [15:0]       w;
  int                error_cnt;
  int                total_checks;

  independent_watchdog i_dut (
    .mclk_in          (mclk_in),
    .rst_b_in         (rst_b),
    .bus_in           (bus_r),
    .rdata_out        (rdata),
    .low_speed_clk_in (lsclk),
    .auto_start_in    (auto_r),
    .opt_word_in      (opt_r),
    .sleep_in         (sleep_r),
    .reset_req_out    (reset_req),
    .nmi_req_out      (nmi_req),
    .count_stop_out   (count_stop)
  );

  count_source_model i_src (
    .mclk_in       (mclk_in),
    .rst_b_in      (rst_b),
    .en_in         (en_r),
    .reset_req_in  (reset_req),
    .nmi_req_in    (nmi_req),
    .lsclk_out     (lsclk),
    .reset_cnt_out (reset_cnt),
    .nmi_cnt_out   (nmi_cnt)
  );

  always #50 mclk_in = ~mclk_in;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    bus_r <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    bus_r <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    bus_r <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk_in);
    bus_r <= '0;
    #1;
    d = rdata;
    @(posedge mclk_in);
  endtask

  task automatic kick;
    wr(OFF_REFRESH, 16'h0000);
    wr(OFF_REFRESH, 16'h00ff);
  endtask

  task automatic ticks(input int n);
    en_r <= 1'b1;
    repeat (n * 8) @(posedge mclk_in);
    en_r <= 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask

  task automatic do_reset(input logic a);
    @(posedge mclk_in);
    auto_r <= a;
    rst_b  <= 1'b0;
    repeat (5) @(posedge mclk_in);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    mclk_in = 1'b0;
    rst_b = 1'b0;
    bus_r = '0;
    auto_r = 1'b0;
    opt_r = '0;
    sleep_r = 1'b0;
    en_r = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    do_reset(1'b0);
    rd(OFF_CTRL, v); chk("ctrl", v, CTRL_RST);
    rd(OFF_RSTSEL, v); chk("rstsel", v, 16'h0000);
    rd(OFF_SLEEP, v); chk("sleepreg", v, 16'h0000);
    rd(OFF_STATUS, v); chk("status", v, 16'h0000);
    rd(OFF_REFRESH, v); chk("refresh", v, 16'h00ff);
    rd(8'h3e, v); chk("unmapped", v, 16'h0000);
    wr(OFF_REFRESH, 16'h0000);
    rd(OFF_REFRESH, v); chk("refresh", v, 16'h0000);
    wr(OFF_REFRESH, 16'h0055);
    rd(OFF_REFRESH, v); chk("refresh", v, 16'h00ff);
    wr(OFF_REFRESH, 16'h00ff);
    rd(OFF_STATUS, v); chk("status", v, 16'h0000);
    $display("test defaults done");
    wr(OFF_CTRL, 16'h3300);
    wr(OFF_RSTSEL, 16'h0080);
    kick();
    rd(OFF_STATUS, v); chk("status", v, 16'h007f);
    wr(OFF_CTRL, 16'h0000);
    rd(OFF_CTRL, v); chk("ctrl", v, 16'h3300);
    ticks(10);
    rd(OFF_STATUS, v); chk("status", v, 16'h0075);
    sleep_r <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk("stop", {15'h0, count_stop}, 16'h0000);
    sleep_r <= 1'b0;
    kick();
    rd(OFF_STATUS, v); chk("status", v, 16'h007f);
    ticks(129);
    chk("resets", {8'h0, reset_cnt}, 16'h0001);
    chk("nmis", {8'h0, nmi_cnt}, 16'h0000);
    rd(OFF_STATUS, v); chk("undf", {14'h0, v[15:14]}, 16'h0001);
    ticks(8);
    rd(OFF_STATUS, w); chk("stopped", w, 16'h4000);
    $display("test register mode done");
    do_reset(1'b0);
    wr(OFF_CTRL, 16'h0300);
    kick();
    rd(OFF_STATUS, v); chk("status", v, 16'h007f);
    kick();
    repeat (2) @(posedge mclk_in);
    chk("nmis", {8'h0, nmi_cnt}, 16'h0001);
    chk("resets", {8'h0, reset_cnt}, 16'h0000);
    rd(OFF_STATUS, v); chk("referr", {15'h0, v[15]}, 16'h0001);
    wr(OFF_STATUS, 16'h0000);
    rd(OFF_STATUS, v); chk("referr", {15'h0, v[15]}, 16'h0000);
    kick();
    rd(OFF_STATUS, v); chk("restart", v, 16'h007f);
    ticks(100);
    kick();
    repeat (2) @(posedge mclk_in);
    chk("nmis", {8'h0, nmi_cnt}, 16'h0001);
    rd(OFF_STATUS, v); chk("status", v, 16'h007f);
    $display("test window done");
    do_reset(1'b0);
    wr(OFF_CTRL, 16'h2101);
    kick();
    rd(OFF_STATUS, v); chk("status", v, 16'h01ff);
    ticks(200);
    kick();
    rd(OFF_STATUS, v); chk("status", v, 16'h01ff);
    ticks(300);
    kick();
    repeat (2) @(posedge mclk_in);
    chk("nmis", {8'h0, nmi_cnt}, 16'h0001);
    $display("test window end done");
    opt_r <= '{1'b1, 1'b0, 2'h3, 2'h3, DIV_16, 2'h0};
    do_reset(1'b1);
    ticks(168);
    rd(OFF_STATUS, v); chk("status", v, 16'h0075);
    wr(OFF_CTRL, 16'h0000);
    rd(OFF_CTRL, v); chk("ctrl", v, CTRL_RST);
    sleep_r <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk("stop", {15'h0, count_stop}, 16'h0001);
    sleep_r <= 1'b0;
    ticks(1900);
    chk("nmis", {8'h0, nmi_cnt}, 16'h0001);
    chk("resets", {8'h0, reset_cnt}, 16'h0000);
    rd(OFF_STATUS, v); chk("reload", {3'h0, v[13:1]}, 16'h003f);
    $display("test auto mode done");
    close_out();
  end
endmodule
